/* bench/irc_led_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Infrared LED driver seen from the carrier pin
// ----------------------------------------------------------------------------
module irc_led_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ir_carrier_pin,
    output int hi_len,
    output int lo_len,
    output int rises
);
    int run_q;
    logic last_q;

    // The LED only sinks current, so it just times each lit and dark stretch in core clocks.
    // An unknown pin level counts as a change, so it can never stretch a lit segment.
    // Non-blocking updates let the bench read the counts without a race at the edge.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 0;
            last_q <= 1'b0;
            hi_len <= 0;
            lo_len <= 0;
            rises <= 0;
        end else if (ir_carrier_pin === last_q) begin
            run_q <= run_q + 1;
        end else begin
            if (last_q) hi_len <= run_q;
            else lo_len <= run_q;
            if (ir_carrier_pin === 1'b1) rises <= rises + 1;
            last_q <= ir_carrier_pin;
            run_q <= 1;
        end
    end
endmodule

/* bench/irc_top_test.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench of the infrared carrier generator
// ----------------------------------------------------------------------------
module ir_remote_carrier_generator_test;
    import irc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ir_carrier_pin;
    logic pulse_irq;
    int hi_len, lo_len, rises, errors, checks;
    logic [7:0] mdl [0:15];

    irc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ir_carrier_pin(ir_carrier_pin), .pulse_irq(pulse_irq));
    irc_led_model led (.core_clk(core_clk), .rst_n(rst_n), .ir_carrier_pin(ir_carrier_pin),
        .hi_len(hi_len), .lo_len(lo_len), .rises(rises));

    // Clock of 25 MHz.
    always #20 core_clk = ~core_clk;

    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_time(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // A write also updates the model; carrier counts keep only six bits, read-only places none.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        if (a == IRC_ADDR_CAR_HIGH || a == IRC_ADDR_CAR_LOW) mdl[a] = d & 8'h3F;
        else if (a <= IRC_ADDR_OUT_BUF) mdl[a] = d;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Cycles until the pulse event is seen, bounded by lim.
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pulse_irq !== 1'b1 && n < lim);
    endtask

    // Cycles out of n in which the pin was lit, looked at once each edge has settled.
    task automatic lit_cycles(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (ir_carrier_pin !== 1'b0) c++;
        end
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog at 60000 cycles, well beyond the thousand or so cycles the tests need.
    initial begin
        #(40 * 60000);
        errors++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] st;
        int h, l, n, r;
        void'($urandom(20377));
        // Idle status: both the carrier and the data phase start high.
        st = 8'((1 << IRC_STAT_CAR_HI_BIT) | (1 << IRC_STAT_DATA_HI_BIT));
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values and the register port, one unmapped index included.
        for (int a = 0; a <= 8; a++) begin
            rd(a[3:0], d);
            chk_reg("reset value", (a == IRC_ADDR_STATUS) ? st : 8'h00, d);
        end
        for (int a = 0; a <= 7; a++) wr(a[3:0], (a == 0) ? 8'($urandom & 8'h37) : 8'($urandom));
        wr(4'hC, 8'h5A);
        for (int a = 0; a <= 6; a++) begin
            rd(a[3:0], d);
            chk_reg("register readback", mdl[a], d);
        end
        rd(4'hC, d);
        chk_reg("unmapped read", 8'h00, d);
        $display("test registers done");
        // Carrier segments on every carrier tap, random independent high and low counts.
        for (int k = 0; k < 4; k++) begin
            h = 1 + $urandom % 6;
            l = 1 + $urandom % 6;
            // Stop the carrier first so a shorter count never meets a running counter.
            wr(IRC_ADDR_MODE, 8'h00);
            wr(IRC_ADDR_CAR_HIGH, h[7:0]);
            wr(IRC_ADDR_CAR_LOW, l[7:0]);
            wr(IRC_ADDR_OUT_DATA, 8'h01);
            wr(IRC_ADDR_MODE, 8'h40 | (k[7:0] << 4));
            r = rises;
            n = 0;
            while (rises < r + 3 && n < 2000) begin
                @(posedge core_clk);
                n++;
            end
            #1;
            chk_time("carrier high length", h << k, hi_len);
            chk_time("carrier low length", l << k, lo_len);
        end
        $display("test carrier done");
        // Gating bit cleared, generator disabled, zero count: the pin stays dark.
        wr(IRC_ADDR_MODE, 8'h40);
        wr(IRC_ADDR_OUT_DATA, 8'h00);
        lit_cycles(40, n);
        chk_time("pin lit with gate low", 0, n);
        wr(IRC_ADDR_OUT_DATA, 8'h01);
        wr(IRC_ADDR_MODE, 8'h00);
        lit_cycles(40, n);
        chk_time("pin lit while disabled", 0, n);
        wr(IRC_ADDR_CAR_HIGH, 8'h00);
        wr(IRC_ADDR_MODE, 8'h40);
        lit_cycles(40, n);
        chk_time("pin lit with zero count", 0, n);
        rd(IRC_ADDR_STATUS, d);
        chk_reg("status with zero count", st, d);
        wait_irq(100, n);
        chk_time("event without timer enable", 100, n);
        $display("test gating done");
        // Data-pulse timer: alternating intervals and buffer copy on each event.
        for (int k = 0; k < 3; k += 2) begin
            h = 1 + $urandom % 6;
            l = 1 + $urandom % 6;
            wr(IRC_ADDR_MODE, 8'h00);
            wr(IRC_ADDR_PULSE_HIGH, h[7:0]);
            wr(IRC_ADDR_PULSE_LOW, l[7:0]);
            wr(IRC_ADDR_OUT_DATA, 8'h00);
            wr(IRC_ADDR_OUT_BUF, 8'h01);
            wr(IRC_ADDR_MODE, 8'h48 | k[7:0]);
            wait_irq(1000, n);
            wait_irq(1000, n);
            chk_time("data low interval", l << k, n);
            wait_irq(1000, n);
            chk_time("data high interval", h << k, n);
            rd(IRC_ADDR_OUT_DATA, d);
            chk_reg("output data after event", 8'h01, d);
        end
        $display("test pulse timer done");
        tally_and_finish();
    end
endmodule

/* verilog/irc_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants of the infrared carrier generator
// ----------------------------------------------------------------------------
package irc_pkg;

    // ------------------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------------------
    localparam logic [3:0] IRC_ADDR_MODE = 4'h0;
    localparam logic [3:0] IRC_ADDR_CAR_HIGH = 4'h1;
    localparam logic [3:0] IRC_ADDR_CAR_LOW = 4'h2;
    localparam logic [3:0] IRC_ADDR_PULSE_HIGH = 4'h3;
    localparam logic [3:0] IRC_ADDR_PULSE_LOW = 4'h4;
    localparam logic [3:0] IRC_ADDR_OUT_DATA = 4'h5;
    localparam logic [3:0] IRC_ADDR_OUT_BUF = 4'h6;
    localparam logic [3:0] IRC_ADDR_STATUS = 4'h7;
    localparam logic [3:0] IRC_ADDR_PULSE_CNT = 4'h8;

    // ------------------------------------------------------------------------
    // Field positions inside the mode register
    // ------------------------------------------------------------------------
    localparam int IRC_MODE_GEN_EN_BIT = 6;
    localparam int IRC_MODE_PULSE_EN_BIT = 3;
    localparam int IRC_MODE_CAR_SEL_LSB = 4;
    localparam int IRC_MODE_PULSE_SEL_LSB = 0;

    // ------------------------------------------------------------------------
    // Field positions inside the status register
    // ------------------------------------------------------------------------
    localparam int IRC_STAT_PIN_BIT = 0;
    localparam int IRC_STAT_CAR_HI_BIT = 1;
    localparam int IRC_STAT_DATA_HI_BIT = 2;
    localparam int IRC_STAT_CAR_OK_BIT = 3;

    // ------------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------------
    localparam logic [7:0] IRC_RST_REG = 8'h00;
    localparam int IRC_TAP_COUNT = 8;
    localparam int IRC_CAR_WIDTH = 6;

endpackage

/* verilog/irc_prescaler.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Free running prescaler, one strobe per power-of-two tap
// ----------------------------------------------------------------------------
module irc_prescaler
    import irc_pkg::*;
#(
    parameter int TAPS = IRC_TAP_COUNT
) (
    input wire logic core_clk,
    input wire logic rst_n,
    irc_tick_if.src tk
);
    // The top bit of a TAPS wide divider would feed no tap, so it is left out.
    logic [TAPS-2:0] div_q;

    // Elaboration refuses tap counts that the divider cannot serve.
    if (TAPS < 2 || TAPS > 16) begin : g_bad_taps
        $error("irc_prescaler: TAPS out of range");
    end

    // The divider never stops, so every tap keeps a fixed phase to the others.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Tap k strobes once every 2**k clocks; tap 0 strobes every clock.
    // prescale tap strobes
    assign tk.tick[0] = 1'b1;
    for (genvar k = 1; k < TAPS; k++) begin : g_tap
        assign tk.tick[k] = &div_q[k-1:0];
    end
endmodule

/* verilog/irc_tick_if.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Prescaler tap strobes between the divider and the generator core
// ----------------------------------------------------------------------------
interface irc_tick_if #(
    parameter int TAPS = 8
);
    logic [TAPS-1:0] tick;

    modport src (output tick);
    modport snk (input tick);
endinterface

/* verilog/irc_top.sv */
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
// Contract
// - While output data bit 0 is one, the carrier waveform appears on the IR pin.
// - While output data bit 0 is zero, the IR pin is held low.
// - Each pulse timer event copies the output buffer into the output data register.
// - The carrier counter runs from the system clock through the selected prescale tap.
// - Carrier high time is tap period times high count, low time tap period times low count.
// - Data high and low intervals are pulse tap period times their counts.
// - Carrier lengths scale linearly with counts up to 3F, one count per tap period.
// - High and low carrier lengths come from separate counts, so duty may be asymmetric.
// - Mode bit 6 enables the whole generator.
// - Mode bit 3 enables the pulse timer and its event.
module irc_top
    import irc_pkg::*;
#(
    parameter int TAPS = IRC_TAP_COUNT
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic ir_carrier_pin,
    output logic pulse_irq
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    irc_tick_if #(.TAPS(TAPS)) tk ();

    logic [7:0] generator_mode_reg_q;
    logic [5:0] carrier_high_count_q;
    logic [5:0] carrier_low_count_q;
    logic [7:0] pulse_high_count_q;
    logic [7:0] pulse_low_count_q;
    logic [7:0] output_data_reg_q;
    logic [7:0] out_buf_q;
    logic [5:0] car_cnt_q;
    logic car_hi_q;
    logic [7:0] pulse_counter_q;
    logic data_hi_q;
    logic pin_q;
    logic irq_q;
    logic [7:0] rdata_q;
    logic gen_en;
    logic pulse_en;
    logic car_ok;
    logic car_run;
    logic car_tick;
    logic pulse_tick;
    logic [5:0] car_target;
    logic [7:0] pulse_target;
    logic car_wrap;
    logic pulse_evt;
    logic [7:0] status;

    // Elaboration refuses tap counts that the 3-bit pulse select cannot serve.
    if (TAPS != 8) begin : g_bad_taps
        $error("irc_top: the pulse tap select needs exactly 8 taps");
    end

    irc_prescaler #(.TAPS(TAPS)) u_pre (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tk(tk.src)
    );

    // ------------------------------------------------------------------------
    // Enables and tap selection
    // ------------------------------------------------------------------------
    // generator master enable
    assign gen_en = generator_mode_reg_q[IRC_MODE_GEN_EN_BIT];
    assign pulse_en = gen_en && generator_mode_reg_q[IRC_MODE_PULSE_EN_BIT];
    assign car_ok = (carrier_high_count_q != 6'h00) && (carrier_low_count_q != 6'h00);
    assign car_run = gen_en && car_ok;
    assign car_tick = tk.tick[generator_mode_reg_q[IRC_MODE_CAR_SEL_LSB +: 2]];
    assign pulse_tick = tk.tick[generator_mode_reg_q[IRC_MODE_PULSE_SEL_LSB +: 3]];

    // ------------------------------------------------------------------------
    // Carrier generator
    // ------------------------------------------------------------------------
    // separate high and low counts
    assign car_target = car_hi_q ? carrier_high_count_q : carrier_low_count_q;
    assign car_wrap = car_run && car_tick && (car_cnt_q == 6'(car_target - 6'h01));

    // The segment counter restarts from zero on every phase change.
    // carrier segment counting
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            car_cnt_q <= 6'h00;
            car_hi_q <= 1'b1;
        end else if (!car_run) begin
            car_cnt_q <= 6'h00;
            car_hi_q <= 1'b1;
        end else if (car_wrap) begin
            car_cnt_q <= 6'h00;
            car_hi_q <= !car_hi_q;
        end else if (car_tick) begin
            car_cnt_q <= car_cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Data pulse timer
    // ------------------------------------------------------------------------
    // A count of zero wraps the 8-bit counter, which gives 256 tap periods.
    assign pulse_target = data_hi_q ? pulse_high_count_q : pulse_low_count_q;
    assign pulse_evt = pulse_en && pulse_tick && (pulse_counter_q == 8'(pulse_target - 8'h01));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_counter_q <= 8'h00;
            data_hi_q <= 1'b1;
        end else if (!pulse_en) begin
            pulse_counter_q <= 8'h00;
            data_hi_q <= 1'b1;
        end else if (pulse_evt) begin
            pulse_counter_q <= 8'h00;
            data_hi_q <= !data_hi_q;
        end else if (pulse_tick) begin
            pulse_counter_q <= pulse_counter_q + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Plain configuration registers written from the register port.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            generator_mode_reg_q <= IRC_RST_REG;
            carrier_high_count_q <= IRC_RST_REG[5:0];
            carrier_low_count_q <= IRC_RST_REG[5:0];
            pulse_high_count_q <= IRC_RST_REG;
            pulse_low_count_q <= IRC_RST_REG;
            out_buf_q <= IRC_RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                IRC_ADDR_MODE: generator_mode_reg_q <= reg_wdata;
                IRC_ADDR_CAR_HIGH: carrier_high_count_q <= reg_wdata[5:0];
                IRC_ADDR_CAR_LOW: carrier_low_count_q <= reg_wdata[5:0];
                IRC_ADDR_PULSE_HIGH: pulse_high_count_q <= reg_wdata;
                IRC_ADDR_PULSE_LOW: pulse_low_count_q <= reg_wdata;
                IRC_ADDR_OUT_BUF: out_buf_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // The timer copy beats a software write in the same cycle, so a bit
    // boundary is never skipped by a late write.
    // buffer to output data copy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_data_reg_q <= IRC_RST_REG;
        end else if (pulse_evt) begin
            output_data_reg_q <= out_buf_q;
        end else if (reg_wr && reg_addr == IRC_ADDR_OUT_DATA) begin
            output_data_reg_q <= reg_wdata;
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    assign status = {4'h0, car_ok, data_hi_q, car_hi_q, pin_q};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                IRC_ADDR_MODE: rdata_q <= generator_mode_reg_q;
                IRC_ADDR_CAR_HIGH: rdata_q <= {2'b00, carrier_high_count_q};
                IRC_ADDR_CAR_LOW: rdata_q <= {2'b00, carrier_low_count_q};
                IRC_ADDR_PULSE_HIGH: rdata_q <= pulse_high_count_q;
                IRC_ADDR_PULSE_LOW: rdata_q <= pulse_low_count_q;
                IRC_ADDR_OUT_DATA: rdata_q <= output_data_reg_q;
                IRC_ADDR_OUT_BUF: rdata_q <= out_buf_q;
                IRC_ADDR_STATUS: rdata_q <= status;
                IRC_ADDR_PULSE_CNT: rdata_q <= pulse_counter_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Pin and event outputs
    // ------------------------------------------------------------------------
    // The pin is registered to keep it glitch free toward the LED driver.
    // gate carrier onto pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pin_q <= output_data_reg_q[0] && car_run && car_hi_q;
            irq_q <= pulse_evt;
        end
    end

    assign ir_carrier_pin = pin_q;
    assign pulse_irq = irq_q;
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_pin_held_low: assert property (!output_data_reg_q[0] |=> !ir_carrier_pin)
        else $error("IR pin high while output bit is zero");
    a_pin_carrier_on: assert property (output_data_reg_q[0] && car_run
        |=> ir_carrier_pin == $past(car_hi_q))
        else $error("IR pin does not follow carrier");
    a_buffer_copy: assert property (pulse_evt |=> output_data_reg_q == $past(out_buf_q)
        && pulse_irq)
        else $error("output buffer not copied on timer event");
    a_tap_spacing: assert property (tk.tick[2] |=> (!tk.tick[2])[*3] ##1 tk.tick[2])
        else $error("tap 2 spacing wrong");
    a_carrier_high_len: assert property (car_run && car_hi_q && !$rose(car_run)
        |-> car_cnt_q < carrier_high_count_q)
        else $error("carrier high segment too long");
    a_carrier_low_len: assert property (car_run && !car_hi_q
        |-> car_cnt_q < carrier_low_count_q)
        else $error("carrier low segment too long");
    a_pulse_toggle: assert property (pulse_evt && $stable(generator_mode_reg_q)
        |=> pulse_counter_q == 8'h00 && data_hi_q != $past(data_hi_q))
        else $error("pulse phase did not toggle");
    a_fast_tap: assert property (generator_mode_reg_q[5:4] == 2'b00 |-> car_tick)
        else $error("undivided tap missed a clock");
    a_gen_disabled: assert property (!gen_en |=> !ir_carrier_pin && car_cnt_q == 6'h00)
        else $error("generator active while disabled");
    a_pulse_disabled: assert property (!pulse_en |=> !pulse_irq)
        else $error("pulse event while timer disabled");
    a_zero_count: assert property (!car_ok |=> !ir_carrier_pin)
        else $error("carrier output with a zero count");

    c_pulse_event: cover property (pulse_evt ##1 pulse_irq);
    c_pin_rise: cover property (!ir_carrier_pin ##1 ir_carrier_pin);
    c_carrier_wrap: cover property (car_wrap && !car_hi_q);
    c_sw_and_copy: cover property (pulse_evt && reg_wr && reg_addr == IRC_ADDR_OUT_DATA);
endmodule
